// File: ump_pkg.sv
// Constants and types shared by the multiprocessor-addressing serial port
package ump_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_CONTROL = 10'H098;
   localparam logic [9:0] IDX_DATA_BUF = 10'H099;
   localparam logic [9:0] IDX_RELOAD = 10'H09A;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'H09B;
   localparam logic [9:0] IDX_IRQ_MASK = 10'H09C;
   localparam int ADDR_W = 12;

   // ------------------------------------------------------------
   // Control register field positions
   // ------------------------------------------------------------
   localparam int CTL_MODE_HI = 7;
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_ADDR_FILTER = 5;
   localparam int CTL_RX_ENABLE = 4;
   localparam int CTL_TX_NINTH = 3;
   localparam int CTL_RX_NINTH = 2;
   localparam int CTL_TX_DONE = 1;
   localparam int CTL_RX_DONE = 0;

   // Interrupt status and mask field positions
   localparam int IRQ_RX_BIT = 0;
   localparam int IRQ_TX_BIT = 1;
   localparam int IRQ_W = 2;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_CONTROL = 8'H00;
   localparam logic [7:0] RST_DATA_BUF = 8'H00;
   localparam logic [7:0] RST_RELOAD = 8'H00;
   localparam logic [1:0] RST_IRQ = 2'H0;

   // ------------------------------------------------------------
   // Frame and baud timing
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_FIXED9 = 2'H2;
   localparam logic [1:0] MODE_VAR9 = 2'H3;
   localparam logic [3:0] OVERSAMPLE_LAST = 4'HF;
   localparam logic [3:0] OVERSAMPLE_MID = 4'H7;
   localparam int FIXED_BIT_DIVIDE = 64;
   localparam int OVERSAMPLE = 16;
   localparam logic [8:0] FIXED_TICK_PERIOD = 9'(FIXED_BIT_DIVIDE / OVERSAMPLE);
   localparam logic [8:0] RELOAD_SPAN = 9'H100;
   localparam logic [3:0] TX_STOP_INDEX = 4'HA;
   localparam logic [3:0] RX_LAST_INDEX = 4'H8;

   typedef enum logic [3:0] {
      RX_IDLE = 4'H1,
      RX_START = 4'H2,
      RX_DATA = 4'H4,
      RX_STOP = 4'H8
   } ump_rx_state_t;

endpackage

// File: ump_baud.sv
// Oversample tick generator for the nine-bit frame modes
`timescale 1ns/1ns
`default_nettype none
module ump_baud (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_fixed_rate,
   input wire logic [7:0] i_reload,
   output logic o_tick
);

   logic [8:0] period;
   logic [8:0] cnt_reg;
   logic [8:0] cnt_next;

   // ------------------------------------------------------------
   // Divider
   // ------------------------------------------------------------
   // One bit time is sixteen ticks, so a bit spans 16 x (256 - reload) clocks, or 64 clocks at the fixed rate
   always_comb begin
      if (i_fixed_rate) begin
         period = ump_pkg::FIXED_TICK_PERIOD;
      end else begin
         period = ump_pkg::RELOAD_SPAN - {1'b0, i_reload};
      end
      if (cnt_reg >= period - 9'H001) begin
         cnt_next = 9'H000;
      end else begin
         cnt_next = cnt_reg + 9'H001;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_reg <= 9'H000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // Reload changes take effect at once; a counter past the new period wraps immediately
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tick <= 1'b0;
      end else begin
         o_tick <= (cnt_next == 9'H000);
      end
   end

endmodule
`default_nettype wire

// File: ump_top.sv
// Nine-bit serial port with multiprocessor address filter and APB registers
`timescale 1ns/1ns
`default_nettype none
module ump_top (
   input wire logic I_CORE_CLK,
   input wire logic I_NRST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic I_RXD,
   output logic O_TXD,
   output logic O_IRQ
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [1:0] mode_reg;
   logic addr_filter_enable_reg;
   logic rx_enable_reg;
   logic tx_ninth_bit_reg;
   logic rx_ninth_bit_reg;
   logic tx_done_flag_reg;
   logic rx_done_flag_reg;
   logic [7:0] reload_reg;
   logic [7:0] rx_buf_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;
   logic setup_phase;
   logic access_done;
   logic wr_done;
   logic rd_done;
   logic [9:0] reg_index;
   logic addr_ok;
   logic [31:0] rd_value;
   logic [7:0] ctl_value;
   logic nine_bit_mode;
   logic tick;
   logic tx_busy_reg;
   logic tx_wait_reg;
   logic [10:0] tx_shift_reg;
   logic [3:0] tx_index_reg;
   logic [3:0] tx_sub_reg;
   logic tx_start;
   logic tx_stop_begin;
   logic rxd_meta_reg;
   logic rxd_sync_reg;
   logic rxd_prev_reg;
   ump_pkg::ump_rx_state_t rx_state_reg;
   logic [3:0] rx_sub_reg;
   logic [3:0] rx_index_reg;
   logic [8:0] rx_shift_reg;
   logic rx_mid;
   logic rx_accept;
   logic [1:0] irq_set;
   logic [1:0] irq_status_next;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   assign setup_phase = I_PSEL && !I_PENABLE;
   assign access_done = I_PSEL && I_PENABLE && O_PREADY;
   assign wr_done = access_done && I_PWRITE && addr_ok;
   assign rd_done = access_done && !I_PWRITE && addr_ok;
   assign reg_index = I_PADDR[11:2];
   assign nine_bit_mode = mode_reg[1];

   assign addr_ok = (I_PADDR[1:0] == 2'H0) && (reg_index == ump_pkg::IDX_CONTROL
      || reg_index == ump_pkg::IDX_DATA_BUF || reg_index == ump_pkg::IDX_RELOAD
      || reg_index == ump_pkg::IDX_IRQ_STATUS || reg_index == ump_pkg::IDX_IRQ_MASK);
   always_comb begin
      ctl_value = {mode_reg, addr_filter_enable_reg, rx_enable_reg, tx_ninth_bit_reg,
         rx_ninth_bit_reg, tx_done_flag_reg, rx_done_flag_reg};
      rd_value = 32'H0000_0000;
      if (addr_ok) begin
         case (reg_index)
            ump_pkg::IDX_CONTROL: rd_value = {24'H00_0000, ctl_value};
            ump_pkg::IDX_DATA_BUF: rd_value = {24'H00_0000, rx_buf_reg};
            ump_pkg::IDX_RELOAD: rd_value = {24'H00_0000, reload_reg};
            ump_pkg::IDX_IRQ_STATUS: rd_value = {30'H0000_0000, irq_status_reg};
            ump_pkg::IDX_IRQ_MASK: rd_value = {30'H0000_0000, irq_mask_reg};
            default: rd_value = 32'H0000_0000;
         endcase
      end
   end

   // Answer is registered at setup, so every transfer takes exactly one access cycle
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA <= 32'H0000_0000;
      end else begin
         O_PREADY <= setup_phase;
         O_PSLVERR <= setup_phase && !addr_ok;
         O_PRDATA <= setup_phase ? rd_value : 32'H0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         mode_reg <= ump_pkg::RST_CONTROL[ump_pkg::CTL_MODE_HI:ump_pkg::CTL_MODE_LO];
         addr_filter_enable_reg <= ump_pkg::RST_CONTROL[ump_pkg::CTL_ADDR_FILTER];
         rx_enable_reg <= ump_pkg::RST_CONTROL[ump_pkg::CTL_RX_ENABLE];
         tx_ninth_bit_reg <= ump_pkg::RST_CONTROL[ump_pkg::CTL_TX_NINTH];
      end else if (wr_done && reg_index == ump_pkg::IDX_CONTROL) begin
         mode_reg <= I_PWDATA[ump_pkg::CTL_MODE_HI:ump_pkg::CTL_MODE_LO];
         // Software clears this after its own address match and sets it after the message
         addr_filter_enable_reg <= I_PWDATA[ump_pkg::CTL_ADDR_FILTER];
         rx_enable_reg <= I_PWDATA[ump_pkg::CTL_RX_ENABLE];
         tx_ninth_bit_reg <= I_PWDATA[ump_pkg::CTL_TX_NINTH];
      end
   end
   // Hardware updates win over a software write in the same cycle
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rx_done_flag_reg <= ump_pkg::RST_CONTROL[ump_pkg::CTL_RX_DONE];
         rx_ninth_bit_reg <= ump_pkg::RST_CONTROL[ump_pkg::CTL_RX_NINTH];
      end else if (rx_accept) begin
         rx_done_flag_reg <= 1'b1;
         rx_ninth_bit_reg <= rx_shift_reg[8];
      end else if (wr_done && reg_index == ump_pkg::IDX_CONTROL) begin
         rx_done_flag_reg <= I_PWDATA[ump_pkg::CTL_RX_DONE];
         rx_ninth_bit_reg <= I_PWDATA[ump_pkg::CTL_RX_NINTH];
      end
   end
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         tx_done_flag_reg <= ump_pkg::RST_CONTROL[ump_pkg::CTL_TX_DONE];
      end else if (tx_stop_begin) begin
         tx_done_flag_reg <= 1'b1;
      end else if (wr_done && reg_index == ump_pkg::IDX_CONTROL) begin
         tx_done_flag_reg <= I_PWDATA[ump_pkg::CTL_TX_DONE];
      end
   end
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         reload_reg <= ump_pkg::RST_RELOAD;
      end else if (wr_done && reg_index == ump_pkg::IDX_RELOAD) begin
         reload_reg <= I_PWDATA[7:0];
      end
   end

   // ------------------------------------------------------------
   // Baud ticks
   // ------------------------------------------------------------
   ump_baud u_baud (
      .i_clk(I_CORE_CLK),
      .i_nrst(I_NRST),
      .i_fixed_rate(mode_reg == ump_pkg::MODE_FIXED9),
      .i_reload(reload_reg),
      .o_tick(tick)
   );

   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   // A write while a frame is in flight is dropped rather than corrupting the frame
   assign tx_start = wr_done && reg_index == ump_pkg::IDX_DATA_BUF
      && nine_bit_mode && !tx_busy_reg;
   assign tx_stop_begin = tx_busy_reg && tick && tx_sub_reg == ump_pkg::OVERSAMPLE_LAST
      && tx_index_reg == ump_pkg::TX_STOP_INDEX - 4'H1;
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         tx_busy_reg <= 1'b0;
         tx_wait_reg <= 1'b0;
         tx_shift_reg <= 11'H7FF;
         tx_index_reg <= 4'H0;
         tx_sub_reg <= 4'H0;
      end else if (tx_start) begin
         tx_busy_reg <= 1'b1;
         tx_wait_reg <= 1'b1;
         // Stop, ninth bit, data LSB first, start; ninth bit marks address or data
         tx_shift_reg <= {1'b1, tx_ninth_bit_reg, I_PWDATA[7:0], 1'b0};
         tx_index_reg <= 4'H0;
         tx_sub_reg <= 4'H0;
      end else if (tx_busy_reg && tick && tx_wait_reg) begin
         tx_wait_reg <= 1'b0; // Start bit waits for a tick so it lasts a whole bit
      end else if (tx_busy_reg && tick) begin
         tx_sub_reg <= tx_sub_reg + 4'H1;
         if (tx_sub_reg == ump_pkg::OVERSAMPLE_LAST) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            if (tx_index_reg == ump_pkg::TX_STOP_INDEX) begin
               tx_busy_reg <= 1'b0;
               tx_index_reg <= 4'H0;
            end else begin
               tx_index_reg <= tx_index_reg + 4'H1;
            end
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_TXD <= 1'b1;
      end else begin
         O_TXD <= (tx_busy_reg && !tx_wait_reg) ? tx_shift_reg[0] : 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rxd_meta_reg <= 1'b1;
         rxd_sync_reg <= 1'b1;
         rxd_prev_reg <= 1'b1;
      end else begin
         rxd_meta_reg <= I_RXD;
         rxd_sync_reg <= rxd_meta_reg;
         rxd_prev_reg <= rxd_sync_reg;
      end
   end
   assign rx_mid = tick && rx_sub_reg == ump_pkg::OVERSAMPLE_MID;
   // No address compare here: software reads the byte and decides
   // While rx_done_flag_reg is clear, address bytes pass; data bytes only with the filter off
   assign rx_accept = rx_state_reg == ump_pkg::RX_STOP && rx_mid && !rx_done_flag_reg
      && (!addr_filter_enable_reg || rx_shift_reg[8]);

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rx_state_reg <= ump_pkg::RX_IDLE;
         rx_sub_reg <= 4'H0;
         rx_index_reg <= 4'H0;
         rx_shift_reg <= 9'H000;
      end else begin
         if (tick) begin
            rx_sub_reg <= rx_sub_reg + 4'H1;
         end
         case (rx_state_reg)
            ump_pkg::RX_IDLE: begin
               if (rx_enable_reg && nine_bit_mode && rxd_prev_reg && !rxd_sync_reg) begin
                  rx_state_reg <= ump_pkg::RX_START;
                  rx_sub_reg <= 4'H0;
               end
            end
            ump_pkg::RX_START: begin
               if (rx_mid) begin
                  // A glitch shorter than half a bit is treated as noise
                  rx_state_reg <= rxd_sync_reg ? ump_pkg::RX_IDLE : ump_pkg::RX_DATA;
                  rx_index_reg <= 4'H0;
               end
            end
            ump_pkg::RX_DATA: begin
               if (rx_mid) begin
                  rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[8:1]};
                  if (rx_index_reg == ump_pkg::RX_LAST_INDEX) begin
                     rx_state_reg <= ump_pkg::RX_STOP;
                  end else begin
                     rx_index_reg <= rx_index_reg + 4'H1;
                  end
               end
            end
            ump_pkg::RX_STOP: begin
               // Stop level is ignored in the nine-bit modes
               if (rx_mid) begin
                  rx_state_reg <= ump_pkg::RX_IDLE;
               end
            end
            default: begin
               rx_state_reg <= ump_pkg::RX_IDLE;
            end
         endcase
      end
   end

   // Receive buffer is separate from the transmit holding path
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rx_buf_reg <= ump_pkg::RST_DATA_BUF;
      end else if (rx_accept) begin
         rx_buf_reg <= rx_shift_reg[7:0];
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   always_comb begin
      irq_set = 2'H0;
      irq_set[ump_pkg::IRQ_RX_BIT] = rx_accept;
      irq_set[ump_pkg::IRQ_TX_BIT] = tx_stop_begin;
      irq_status_next = irq_status_reg;
      // Only bits returned by the read are cleared; a new event wins the same cycle
      if (rd_done && reg_index == ump_pkg::IDX_IRQ_STATUS) begin
         irq_status_next = irq_status_reg & ~O_PRDATA[ump_pkg::IRQ_W-1:0];
      end
      irq_status_next = irq_status_next | irq_set;
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         irq_status_reg <= ump_pkg::RST_IRQ;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         irq_mask_reg <= ump_pkg::RST_IRQ;
      end else if (wr_done && reg_index == ump_pkg::IDX_IRQ_MASK) begin
         irq_mask_reg <= I_PWDATA[ump_pkg::IRQ_W-1:0];
      end
   end
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= |(irq_status_reg & irq_mask_reg);
      end
   end

endmodule
`default_nettype wire

// File: ump_props.sv
// Checker of the serial port's bus answers and line timing
`timescale 1ns/1ns
`default_nettype none
module ump_props (
   input wire logic I_CORE_CLK,
   input wire logic I_NRST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic I_RXD,
   input wire logic O_TXD,
   input wire logic O_IRQ
);
   localparam logic [11:0] A_MASK = {ump_pkg::IDX_IRQ_MASK, 2'B00};
   logic setup;
   assign setup = I_PSEL && !I_PENABLE;
   default clocking @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_NRST);
   // ------------------------------
   // Assertions
   // ------------------------------
   a_ready_after_setup: assert property (setup |=> O_PREADY)
      else $error("no ready after setup");
   a_ready_has_setup: assert property (O_PREADY |-> $past(setup))
      else $error("ready without setup");
   a_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   a_error_reads_zero: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'H0)
      else $error("bad error answer");
   a_misalign_error: assert property (setup && I_PADDR[1:0] != 2'H0 |=> O_PSLVERR)
      else $error("misaligned access accepted");
   a_idle_rdata_zero: assert property (!O_PREADY |-> O_PRDATA == 32'H0)
      else $error("read data outside access");
   // Shortest bit is 16 clocks, so any level must hold at least 8
   a_low_bit_len: assert property ($fell(O_TXD) |-> !O_TXD [*8])
      else $error("low bit too short");
   a_high_bit_len: assert property ($rose(O_TXD) |-> O_TXD [*8])
      else $error("high bit too short");
   a_mask_off_irq: assert property (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == A_MASK
      && I_PWDATA[1:0] == 2'H0 |-> ##[1:3] !O_IRQ)
      else $error("irq stays up with mask off");
   c_irq_rise: cover property ($rose(O_IRQ));
   c_bus_error: cover property (O_PSLVERR);
   c_tx_start: cover property ($fell(O_TXD));
endmodule
bind ump_top ump_props ump_props_inst (
   .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
   .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
   .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_RXD(I_RXD), .O_TXD(O_TXD), .O_IRQ(O_IRQ)
);
`default_nettype wire

// File: ump_remote.sv
// Remote processor model on the shared serial line
`timescale 1ns/1ns
`default_nettype none
module ump_remote (
   input wire logic i_clk,
   input wire logic i_line,
   output logic o_line
);
   int bit_clks = 16;
   logic [9:0] got_q[$];
   initial begin
      o_line = 1'B1;
   end
   // Address byte has ninth bit one, data byte zero; line idles high
   task automatic send_frame(input logic [7:0] data, input logic ninth);
      logic [10:0] frame;
      frame = {1'B1, ninth, data, 1'B0};
      for (int i = 0; i < 11; i++) begin
         o_line <= frame[i];
         repeat (bit_clks) @(posedge i_clk);
      end
   endtask
   // Two samples per bit: a bit time off by one clock drifts apart by the stop
   always begin : rx_loop
      logic [10:0] a;
      logic [10:0] b;
      @(negedge i_line);
      for (int i = 0; i < 11; i++) begin
         repeat (2) @(posedge i_clk);
         a[i] = i_line;
         repeat (bit_clks - 4) @(posedge i_clk);
         b[i] = i_line;
         repeat (2) @(posedge i_clk);
      end
      got_q.push_back({a != b || a[0] || !a[10], a[9:1]});
   end
endmodule
`default_nettype wire

// File: uart_multiproc_addressing_bench.sv
// Self-checking bench for the multiprocessor serial port
`timescale 1ns/1ns
`default_nettype none
module uart_multiproc_addressing_bench;
   localparam logic [11:0] A_CTL = {ump_pkg::IDX_CONTROL, 2'B00};
   localparam logic [11:0] A_BUF = {ump_pkg::IDX_DATA_BUF, 2'B00};
   localparam logic [11:0] A_REL = {ump_pkg::IDX_RELOAD, 2'B00};
   localparam logic [11:0] A_STA = {ump_pkg::IDX_IRQ_STATUS, 2'B00};
   localparam logic [11:0] A_MSK = {ump_pkg::IDX_IRQ_MASK, 2'B00};
   logic clk = 1'B0;
   logic nrst = 1'B0;
   logic psel = 1'B0;
   logic penable = 1'B0;
   logic pwrite = 1'B0;
   logic [11:0] paddr = 12'H000;
   logic [31:0] pwdata = 32'H0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, rxd, txd, irq, err;
   int failures = 0;
   int cmp_count = 0;
   int unsigned seed = 40683;
   int m_rxbuf = 0;
   int m_rxdone = 0;
   int m_rxninth = 0;
   int m_filter = 0;
   int m_status = 0;
   // Filter set, cleared after an address, set again after the message
   int ctl_tab[7] = '{240, 0, 0, 208, 208, 240, 0};
   logic nin_tab[7] = '{0, 1, 1, 0, 0, 0, 1};
   int rel_tab[3] = '{244, 208, 0};
   ump_top ump_top_inst (.I_CORE_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RXD(rxd), .O_TXD(txd), .O_IRQ(irq));
   ump_remote ump_remote_inst (.i_clk(clk), .i_line(txd), .o_line(rxd));
   initial begin
      forever #2 clk = ~clk;
   end
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic tally_and_finish();
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %0h want %0h", $time, msg, seen, exp);
      end
   endtask
   function automatic logic [7:0] rand8();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // Request held until pready is seen high; released one edge later
   task automatic apb(input logic wr_en, input logic [11:0] addr, input logic [31:0] wd);
      int n;
      psel <= 1'B1;
      pwrite <= wr_en;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'B1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'B1 && n < 16);
      if (pready !== 1'B1) begin
         failures++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'B0;
      penable <= 1'B0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
      apb(1'B1, addr, wd);
   endtask
   task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp, input string msg);
      apb(1'B0, addr, 32'H0);
      check(rd, exp, msg);
   endtask
   // Any byte value may serve as an address; matching is software's task
   task automatic rx_step(input int ctl, input logic ninth);
      logic [7:0] d;
      d = rand8();
      if (ctl != 0) begin
         wr(A_CTL, 32'(ctl));
         m_filter = (ctl >> 5) & 1;
         m_rxninth = (ctl >> 2) & 1;
         m_rxdone = ctl & 1;
      end
      ump_remote_inst.send_frame(d, ninth);
      repeat (4) @(posedge clk);
      if (m_rxdone == 0 && (m_filter == 0 || ninth)) begin
         m_rxbuf = d;
         m_rxninth = ninth;
         m_rxdone = 1;
         m_status = 1;
      end
      check(irq, 32'(m_status), "irq level");
      rdchk(A_CTL, 32'(208 | m_filter << 5 | m_rxninth << 2 | m_rxdone), "ctl");
      rdchk(A_BUF, 32'(m_rxbuf), "rx buffer");
      rdchk(A_STA, 32'(m_status), "status");
      m_status = 0;
   endtask
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      logic [7:0] d;
      logic nb;
      int per;
      int n;
      int ctl;
      repeat (3) @(posedge clk);
      nrst <= 1'B1;
      for (int i = 0; i < 5; i++) begin
         rdchk(A_CTL + 12'(4 * i), 32'H0, "reset value");
         check(err, 1'B0, "reset err");
      end
      rdchk(12'H274, 32'H0, "unmapped");
      check(err, 1'B1, "unmapped err");
      wr(A_CTL + 12'H1, 32'HFF);
      check(err, 1'B1, "misaligned err");
      rdchk(A_CTL, 32'H0, "misaligned side effect");
      wr(A_REL, 32'HFF);
      wr(A_MSK, 32'H3);
      for (int i = 0; i < 7; i++) begin
         rx_step(ctl_tab[i], nin_tab[i]);
      end
      wr(A_CTL, 32'HF0);
      d = rand8();
      m_rxbuf = d;
      ump_remote_inst.send_frame(d, 1'B1);
      wr(A_MSK, 32'H0);
      repeat (3) @(posedge clk);
      check(irq, 1'B0, "masked irq");
      wr(A_MSK, 32'H1);
      repeat (3) @(posedge clk);
      check(irq, 1'B1, "unmasked irq");
      rdchk(A_STA, 32'H1, "status set");
      repeat (3) @(posedge clk);
      check(irq, 1'B0, "irq after clear");
      for (int i = 0; i < 3; i++) begin
         per = (i == 2) ? ump_pkg::FIXED_BIT_DIVIDE : 16 * (256 - rel_tab[i]);
         ump_remote_inst.bit_clks = per;
         d = rand8();
         nb = i[0];
         ctl = ((i == 2) ? 128 : 192) | nb << 3;
         wr(A_REL, 32'(rel_tab[i]));
         wr(A_CTL, 32'(ctl));
         wr(A_BUF, 32'(d));
         rdchk(A_BUF, 32'(m_rxbuf), "rx buffer kept");
         n = 0;
         while (ump_remote_inst.got_q.size() == 0 && n < 12 * per) begin
            @(posedge clk);
            n++;
         end
         if (ump_remote_inst.got_q.size() == 0) begin
            check(32'H0, 32'H1, "no frame");
         end else begin
            check(32'(ump_remote_inst.got_q.pop_front()), 32'({1'B0, nb, d}), "frame");
         end
         rdchk(A_CTL, 32'(ctl | 2), "tx done");
         rdchk(A_STA, 32'H2, "tx event");
      end
      wr(A_CTL, 32'H08);
      wr(A_BUF, 32'(rand8()));
      repeat (300) @(posedge clk);
      check(32'(ump_remote_inst.got_q.size()), 32'H0, "idle mode sent");
      check(txd, 1'B1, "idle line");
      tally_and_finish();
   end
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
